// [include/sbsp_pkg.sv]
package sbsp_pkg;

  // ---------------------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------------------
  localparam int ADDR_W  = 17;
  localparam int DATA_W  = 18;
  localparam int LANES   = 2;
  localparam int LANE_W  = 9;
  localparam int BURST_W = 2;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 17'h00000;
  localparam logic [BURST_W-1:0] COUNT_RST = 2'h0;

  typedef enum logic [2:0] {
    SBSP_DESEL = 3'b001,
    SBSP_FIRST = 3'b010,
    SBSP_BURST = 3'b100
  } sbsp_state_t;

  typedef struct packed {
    logic                 proc_strobe_n;
    logic                 ctrl_strobe_n;
    logic                 advance_n;
    logic                 sel_primary_n;
    logic                 sel_depth_high;
    logic                 sel_depth_low_n;
    logic [LANES-1:0]     lane_write_n;
    logic                 byte_gate_n;
    logic                 all_bytes_n;
    logic [ADDR_W-1:0]    addr;
  } sbsp_ctrl_t;

endpackage

// [core/sbsp_burst_addr.sv]
`timescale 1ns/100ps
`default_nettype none

module sbsp_burst_addr #(
  parameter int CNT_W = 2
) (
  // Start and count
  input  wire logic [CNT_W-1:0] start_in,
  input  wire logic [CNT_W-1:0] count_in,
  input  wire logic             interleave_in,
  // Result
  output logic      [CNT_W-1:0] low_bits_out
);

  wire [CNT_W-1:0] linear_bits = start_in + count_in;
  wire [CNT_W-1:0] inter_bits  = start_in ^ count_in;

  assign low_bits_out = interleave_in ? inter_bits : linear_bits;

endmodule

`default_nettype wire

// [core/sbsp_port.sv]
// Notes on behaviour
// - All synchronous inputs are registered on the rising clock edge.
// - Strap high picks interleaved burst order, low picks linear.
// - A 2-bit counter clears at burst start and advances through the burst.
// - Either address strobe starts a burst access.
// - Address and selects latch only on edges with an active strobe.
// - Addresses after the first come from the internal counter.
// - Address picks one of 128 K words; sampled only when selected.
// - Counter clears to zero on each selected new address; the low two bits stay in the base.
// - Counter steps on an edge during a burst with advance low.
// - Byte-lane selects write only when the byte gate is low.
// - Global write low writes every byte regardless of lane selects.
// - Processor strobe starts no access while the primary select is high, but still masks the controller strobe.
// - Primary select is sampled only when a new address is loaded.
// - Burst timing is two clocks first, then one clock each.
// - Output enable and sleep act through the clocked output register.
// - With both strobes low only the processor strobe counts.
// - Selected only with primary low, depth-high high, depth-low low.
// - Output enable is masked on the first read after deselect.
// - The two-bit counter wraps after four addresses.
`timescale 1ns/100ps
`default_nettype none

module sbsp_port #(
  parameter int ADDR_W = sbsp_pkg::ADDR_W,
  parameter int DATA_W = sbsp_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  // Synchronous bus
  input  wire sbsp_pkg::sbsp_ctrl_t bus_in,
  input  wire logic [DATA_W-1:0] dq_in,
  // Static strap and asynchronous controls
  input  wire logic              burst_order_in,
  input  wire logic              output_enable_n_in,
  input  wire logic              sleep_request_in,
  // Data pins
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_n_out
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (ADDR_W != sbsp_pkg::ADDR_W || DATA_W != sbsp_pkg::LANES * sbsp_pkg::LANE_W) begin : g_chk
    $error("sbsp_port supports the 128 K by 18 organisation only");
  end

  localparam int LW = sbsp_pkg::LANE_W;
  localparam int CW = sbsp_pkg::BURST_W;

  // ---------------------------------------------------------------------------
  // Input registers
  // ---------------------------------------------------------------------------
  sbsp_pkg::sbsp_ctrl_t bus_q;
  logic [DATA_W-1:0]    din_q;
  logic                 order_q;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_q   <= '{proc_strobe_n: 1'b1, ctrl_strobe_n: 1'b1, advance_n: 1'b1,
                   sel_primary_n: 1'b1, sel_depth_high: 1'b0, sel_depth_low_n: 1'b1,
                   lane_write_n: 2'h3, byte_gate_n: 1'b1, all_bytes_n: 1'b1,
                   addr: sbsp_pkg::ADDR_RST};
      din_q   <= 18'h00000;
      order_q <= 1'b0;
    end else begin
      bus_q   <= bus_in;
      din_q   <= dq_in;
      order_q <= burst_order_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Address strobe decode
  // ---------------------------------------------------------------------------
  // The strobes are acted on from the registered copy, so each decision
  // describes the edge at which the inputs were sampled.
  wire proc_take    = ~bus_q.proc_strobe_n & ~bus_q.sel_primary_n;
  wire ctrl_take    = ~bus_q.ctrl_strobe_n & bus_q.proc_strobe_n;
  wire new_addr     = proc_take | ctrl_take;
  wire selected     = ~bus_q.sel_primary_n & bus_q.sel_depth_high
                      & ~bus_q.sel_depth_low_n;
  wire new_select   = new_addr & selected;
  wire new_deselect = new_addr & ~selected;
  wire write_any    = ~bus_q.all_bytes_n | (~bus_q.byte_gate_n & ~(&bus_q.lane_write_n));

  // ---------------------------------------------------------------------------
  // Burst state
  // ---------------------------------------------------------------------------
  sbsp_pkg::sbsp_state_t state_q;
  sbsp_pkg::sbsp_state_t state_d;
  logic [ADDR_W-1:0]     base_q;
  logic [CW-1:0]         count_q;
  logic                  was_desel_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      sbsp_pkg::SBSP_DESEL: begin
        if (new_select) state_d = sbsp_pkg::SBSP_FIRST;
      end
      sbsp_pkg::SBSP_FIRST, sbsp_pkg::SBSP_BURST: begin
        if (new_deselect) state_d = sbsp_pkg::SBSP_DESEL;
        else if (new_select) state_d = sbsp_pkg::SBSP_FIRST;
        else state_d = sbsp_pkg::SBSP_BURST;
      end
      default: state_d = sbsp_pkg::SBSP_DESEL;
    endcase
  end

  wire in_burst = state_q != sbsp_pkg::SBSP_DESEL;
  wire step     = in_burst & ~new_addr & ~bus_q.advance_n;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q     <= sbsp_pkg::SBSP_DESEL;
      base_q      <= sbsp_pkg::ADDR_RST;
      count_q     <= sbsp_pkg::COUNT_RST;
      was_desel_q <= 1'b1;
    end else begin
      state_q <= state_d;
      if (new_select) begin
        base_q  <= bus_q.addr;
        count_q <= sbsp_pkg::COUNT_RST;
      end else if (step) begin
        count_q <= count_q + 2'h1;
      end
      was_desel_q <= (state_q == sbsp_pkg::SBSP_DESEL);
    end
  end

  // ---------------------------------------------------------------------------
  // Address formation
  // ---------------------------------------------------------------------------
  logic [CW-1:0] low_bits;

  sbsp_burst_addr #(
    .CNT_W (CW)
  ) u_burst (
    .start_in      (base_q[CW-1:0]),
    .count_in      (count_q),
    .interleave_in (order_q),
    .low_bits_out  (low_bits)
  );

  wire [ADDR_W-1:0] cur_addr = {base_q[ADDR_W-1:CW], low_bits};

  // ---------------------------------------------------------------------------
  // Array and write path
  // ---------------------------------------------------------------------------
  // Write data is the word registered alongside the controls. Writes are
  // performed on the access address current at that edge, one word per clock.
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [LW-1:0]     lane_data [sbsp_pkg::LANES];
  wire  [sbsp_pkg::LANES-1:0] lane_we;

  for (genvar g = 0; g < sbsp_pkg::LANES; g++) begin : g_lane
    assign lane_we[g] = in_burst & ~sleep_request_in
                        & (~bus_q.all_bytes_n
                           | (~bus_q.byte_gate_n & ~bus_q.lane_write_n[g]));
    assign lane_data[g] = din_q[g*LW +: LW];
  end

  // One process owns the array, so every word has a single writer. The lane
  // enables only pick which halves of the addressed word take new data.
  always_ff @(posedge clk_in) begin
    for (int l = 0; l < sbsp_pkg::LANES; l++) begin
      if (lane_we[l]) begin
        mem[cur_addr][l*LW +: LW] <= lane_data[l];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read path and output control
  // ---------------------------------------------------------------------------
  // The array lookup is registered once, so a read returns one clock after the
  // sampled address: the first access costs two clocks from the strobe and
  // each advanced beat one more clock.
  logic [DATA_W-1:0] dq_q;
  logic              oe_n_q;

  wire first_after_desel = (state_q == sbsp_pkg::SBSP_FIRST) & was_desel_q;
  wire drive_ok = in_burst & ~write_any & ~first_after_desel
                  & ~sleep_request_in & ~output_enable_n_in;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dq_q   <= 18'h00000;
      oe_n_q <= 1'b1;
    end else begin
      dq_q   <= mem[cur_addr];
      oe_n_q <= ~drive_ok;
    end
  end

  // Output enable and sleep are sampled each clock here: a fully asynchronous
  // gate would break the rule that top outputs leave flip-flops directly.
  assign dq_out      = dq_q;
  assign dq_oe_n_out = oe_n_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  proc_block_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!bus_q.proc_strobe_n && bus_q.sel_primary_n && bus_q.ctrl_strobe_n) |-> !new_addr)
    else $error("processor strobe taken while deselected");

  strobe_prio_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!bus_q.proc_strobe_n && !bus_q.ctrl_strobe_n && bus_q.sel_primary_n) |-> !new_addr)
    else $error("controller strobe honoured alongside processor strobe");

  load_start_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    new_select |=> (count_q == 2'h0 && base_q == $past(bus_q.addr)))
    else $error("new address not loaded");

  count_step_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    step |=> count_q == $past(count_q) + 2'h1)
    else $error("burst counter did not advance");

  count_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!new_select && !step) |=> $stable(count_q) && $stable(base_q))
    else $error("burst address moved without advance");

  desel_go_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    new_deselect |=> state_q == sbsp_pkg::SBSP_DESEL)
    else $error("device stayed selected");

  oe_mask_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    first_after_desel |=> dq_oe_n_out)
    else $error("data driven on first read after deselect");

  global_wr_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (in_burst && !bus_q.all_bytes_n && !sleep_request_in) |-> &lane_we)
    else $error("global write missed a lane");

  lane_gate_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (bus_q.all_bytes_n && bus_q.byte_gate_n) |-> lane_we == 2'h0)
    else $error("lane written without byte gate");

  wrap_addr_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cur_addr[ADDR_W-1:CW] == base_q[ADDR_W-1:CW])
    else $error("burst carried into upper address");

  // ---------------------------------------------------------------------------
  // Output and strobe checks
  // ---------------------------------------------------------------------------
  // These watch the sampled copies of output enable and sleep. A controller
  // that toggles either between edges sees the effect one clock later, which
  // is the price of keeping every output on a flip-flop.
  proc_take_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!bus_q.proc_strobe_n && !bus_q.sel_primary_n) |-> new_addr)
    else $error("processor strobe not taken");

  ctrl_take_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (bus_q.proc_strobe_n && !bus_q.ctrl_strobe_n) |-> new_addr)
    else $error("controller strobe not taken");

  first_state_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    new_select |=> state_q == sbsp_pkg::SBSP_FIRST)
    else $error("selected strobe did not start a burst");

  start_bits_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    new_select |=> cur_addr[CW-1:0] == $past(bus_q.addr[CW-1:0]))
    else $error("burst did not begin at its start address");

  desel_step_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !in_burst |-> !step)
    else $error("counter advanced while deselected");

  adv_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (in_burst && !new_addr && bus_q.advance_n) |=> $stable(count_q))
    else $error("counter advanced without advance");

  sleep_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sleep_request_in |-> lane_we == 2'h0)
    else $error("array written during sleep");

  sleep_drive_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sleep_request_in |=> dq_oe_n_out)
    else $error("data driven during sleep");

  oe_off_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    output_enable_n_in |=> dq_oe_n_out)
    else $error("data driven with output enable high");

  desel_drive_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !in_burst |=> dq_oe_n_out)
    else $error("data driven while deselected");

  write_drive_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (in_burst && write_any) |=> dq_oe_n_out)
    else $error("data driven during a write");

endmodule

`default_nettype wire

// [testbench/sbsp_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none

module sbsp_ctrl_model (
  // Clock
  input  wire logic                   clk_in,
  // Synchronous bus toward the port
  output var sbsp_pkg::sbsp_ctrl_t    bus_out,
  output logic [sbsp_pkg::DATA_W-1:0] dq_out
);
  initial begin
    bus_out = '1;
    dq_out = 18'h00000;
  end

  // ---------------------------------------------------------------------------
  // One bus cycle
  // ---------------------------------------------------------------------------
  // Outside write cycles the data lines toggle, so stale write data is never mistaken
  // for a valid word.
  task automatic cyc(input sbsp_pkg::sbsp_ctrl_t c, input logic [sbsp_pkg::DATA_W-1:0] d,
                     input logic wr, input logic gate_ok);
    sbsp_pkg::sbsp_ctrl_t v;
    v = c;
    if (gate_ok && !(&c.lane_write_n)) v.byte_gate_n = 1'b0;
    @(posedge clk_in);
    bus_out <= v;
    dq_out <= wr ? d : ~dq_out;
  endtask
endmodule

`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // ---------------------------------------------------------------------------
  // Signals and bench state
  // ---------------------------------------------------------------------------
  logic                        clk_in = 1'b0;
  logic                        sys_rst_in = 1'b1;
  logic                        burst_order_in = 1'b0;
  logic                        output_enable_n_in = 1'b0;
  logic                        sleep_request_in = 1'b0;
  sbsp_pkg::sbsp_ctrl_t        bus;
  logic [17:0]                 dq_w;
  logic [17:0]                 dq_out;
  logic                        dq_oe_n_out;
  logic [17:0]                 mem [logic [16:0]];
  logic [17:0]                 exp_q [$];
  logic [17:0]                 last_w;
  int                          n_errors = 0;
  int                          checked = 0;

  always #2 clk_in = ~clk_in;

  sbsp_ctrl_model ctl (.clk_in(clk_in), .bus_out(bus), .dq_out(dq_w));

  sbsp_port DUT (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus), .dq_in(dq_w),
    .burst_order_in(burst_order_in), .output_enable_n_in(output_enable_n_in),
    .sleep_request_in(sleep_request_in), .dq_out(dq_out), .dq_oe_n_out(dq_oe_n_out)
  );

  // ---------------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] want);
    checked++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Sampling on the falling edge keeps the compare clear of the launch edge.
  always @(negedge clk_in) begin
    if (!sys_rst_in && dq_oe_n_out === 1'b0 && exp_q.size() > 0)
      check("read data", dq_out, exp_q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // Bus operations
  // ---------------------------------------------------------------------------
  function automatic sbsp_pkg::sbsp_ctrl_t mk(input logic ps, input logic cs, input logic burst_advance_n,
                                               input logic p1, input logic [16:0] a);
    mk = '1;
    mk.proc_strobe_n = ps;
    mk.ctrl_strobe_n = cs;
    mk.advance_n = burst_advance_n;
    mk.sel_primary_n = p1;
    mk.sel_depth_low_n = 1'b0;
    mk.addr = a;
  endfunction

  // Mode 0 writes all bytes, mode 1 gated lane 0 only, mode 2 lane select without gate.
  task automatic wr(input logic [16:0] a, input logic [17:0] d, input int mode);
    sbsp_pkg::sbsp_ctrl_t c;
    ctl.cyc(mk(1'b1, 1'b0, 1'b1, 1'b0, a), dq_w, 1'b0, 1'b1);
    c = mk(1'b1, 1'b1, 1'b1, 1'b0, a);
    c.all_bytes_n = (mode != 0);
    c.lane_write_n = (mode == 0) ? 2'h3 : 2'h2;
    ctl.cyc(c, d, 1'b1, mode == 1);
    ctl.cyc(mk(1'b1, 1'b1, 1'b1, 1'b0, a), dq_w, 1'b0, 1'b1);
    if (!sleep_request_in && mode == 0) mem[a] = d;
    if (!sleep_request_in && mode == 1) mem[a][8:0] = d[8:0];
  endtask

  task automatic rd(input logic [16:0] a, input logic ps, input int skip);
    sbsp_pkg::sbsp_ctrl_t c;
    logic [1:0] lo;
    for (int k = 0; k < 7; k++) begin
      c = mk(1'b1, 1'b1, k > 3, 1'($urandom_range(1)), 17'($urandom));
      if (k == 0) c = mk(ps, 1'b0, 1'b1, 1'b0, a);
      ctl.cyc(c, dq_w, 1'b0, 1'b1);
      lo = burst_order_in ? a[1:0] ^ 2'(k - 3) : a[1:0] + 2'(k - 3);
      last_w = mem[{a[16:2], lo}];
      if (k >= 3 + skip) exp_q.push_back(last_w);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    sbsp_pkg::sbsp_ctrl_t c;
    logic [16:0] base;
    void'($urandom(82));
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int b = 0; b < 4; b++) begin
      base = 17'($urandom);
      burst_order_in <= b[0];
      for (int i = 0; i < 4; i++) wr({base[16:2], 2'(i)}, 18'($urandom), 0);
      wr({base[16:2], 2'h1}, 18'($urandom), 1);
      wr({base[16:2], 2'h2}, 18'($urandom), 2);
      sleep_request_in <= 1'b1;
      wr({base[16:2], 2'h3}, 18'($urandom), 0);
      repeat (2) @(posedge clk_in);
      sleep_request_in <= 1'b0;
      rd(base, b[1], 0);
    end
    for (int k = 0; k < 5; k++) begin
      ctl.cyc(mk(k != 0, k != 0, 1'b1, 1'b1, 17'($urandom)), dq_w, 1'b0, 1'b1);
      if (k >= 3) exp_q.push_back(last_w);
    end
    c = mk(1'b1, 1'b0, 1'b1, 1'b0, base);
    c.sel_depth_high = 1'b0;
    ctl.cyc(c, dq_w, 1'b0, 1'b1);
    repeat (3) ctl.cyc(mk(1'b1, 1'b1, 1'b1, 1'b0, base), dq_w, 1'b0, 1'b1);
    #1;
    check("drive after deselect", 18'(dq_oe_n_out), 18'h00001);
    rd(base, 1'b0, 1);
    repeat (4) @(posedge clk_in);
    check("pending reads", 18'(exp_q.size()), 18'h00000);
    stop_test();
  end
endmodule

`default_nettype wire
